//--- tsv_consts.svh
`ifndef TSV_CONSTS_SVH
`define TSV_CONSTS_SVH
// ==========================================================
// Register map (byte addresses, one word each)
`define TSV_OFS_CTRL 8'h00
`define TSV_OFS_STATUS 8'h04
`define TSV_OFS_ERRCODE 8'h08
`define TSV_OFS_COUNT 8'h0C
// ==========================================================
// Field positions
`define TSV_CTRL_MODE64_BIT 0
`define TSV_STAT_CAUSE_LSB 0
`define TSV_STAT_NEWCTX_BIT 8
`define TSV_STAT_VALID_BIT 9
// ==========================================================
// Reset values
`define TSV_CTRL_RST 1'b0
`define TSV_COUNT_RST 16'h0000
// ==========================================================
// Fault identity and task-state limits
`define TSV_VECTOR 8'h0A
`define TSV_MIN_LIMIT_32 32'h0000_0067
`define TSV_MIN_LIMIT_16 32'h0000_002C
// ==========================================================
// Descriptor types as {system_n, type[3:0]}
`define TSV_T_AVAIL16 5'h01
`define TSV_T_BUSY16 5'h03
`define TSV_T_AVAIL32 5'h09
`define TSV_T_BUSY32 5'h0B
`define TSV_T_UPPER 5'h00
`endif

//--- tsv_pkg.sv
package tsv_pkg;
   // Operation that asks for task-state checking
   typedef enum logic [2:0] {
      TSV_OP_JMP, TSV_OP_CALL, TSV_OP_EXC, TSV_OP_INTERRUPT_RETURN_INSTRUCTION, TSV_OP_LTR, TSV_OP_PRIV
   } tsv_op_t;

   typedef enum logic [1:0] {TSV_ST_IDLE, TSV_ST_PRE, TSV_ST_POST} tsv_state_t;

   typedef struct packed {
      tsv_state_t st;
      tsv_op_t op;
      logic busy;
      logic fault;
      logic done;
      logic commit;
      logic seg_load;
      logic new_ctx;
      logic [4:0] cause;
      logic [15:0] err;
      logic [63:0] ret_ip;
      logic mode64;
      logic stat_valid;
      logic [4:0] last_cause;
      logic last_ctx;
      logic [15:0] last_err;
      logic [15:0] fault_cnt;
      logic wb_ack;
      logic [31:0] wb_dat;
   } tsv_regs_t;
endpackage

//--- tsv_fault_unit.sv
// Functional notes
// - Fault if task-state limit below format minimum
// - Return switch: local, over-limit, or idle selector faults
// - Return switch: bad back-link fetch, null, type
// - New descriptor beyond global limit or unwritable
// - Old save faults; jump/return: old descriptor unwritable
// - Call/exception: unwritable new back-link faults
// - Lock: null, local, or unavailable type
// - Invalid or absent local table faults
// - Stack selector limit, null, type, writability
// - Stack privilege levels must equal current
// - Code selector limit, null, non-code type
// - Code privilege mismatch by conformity faults
// - Data selector limit or unreadable type
// - Nonconforming code data with higher privilege
// - Load-task-register selector and type checks
// - Wide mode: old type, upper type, base
// - Privilege change: stack pointer fetch faults
// - Old context before commit, new after
// - Commit when task register and link set
// - Error code holds index and external bit
// - Return pointer: starting or first new instruction
// - Vector ten, fault class
// - After commit load segments, skip further checks
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps
`include "tsv_consts.svh"
module tsv_fault_unit (
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_stb_i,
   input wire logic wb_cyc_i,
   output logic wb_ack_o,
   // Request from the core, held stable while busy_o is high
   input wire logic start_i,
   input wire tsv_pkg::tsv_op_t op_i,
   input wire logic ext_i,
   input wire logic [1:0] cpl_i,
   input wire logic [15:0] gdt_limit_i,
   input wire logic [15:0] ldt_limit_i,
   input wire logic [63:0] insn_ip_i,
   input wire logic [63:0] new_ip_i,
   // Incoming task state
   input wire logic [15:0] tss_sel_i,
   input wire logic [31:0] tss_limit_i,
   input wire logic tss_is32_i,
   input wire logic [4:0] tss_type_i,
   input wire logic [4:0] tss_upper_type_i,
   input wire logic tss_base_canon_i,
   input wire logic new_writable_i,
   input wire logic old_save_fault_i,
   input wire logic old_writable_i,
   input wire logic link_write_fault_i,
   input wire logic link_fetch_fault_i,
   input wire logic [15:0] link_sel_i,
   input wire logic [4:0] link_type_i,
   // Selectors loaded from the task state
   input wire logic [15:0] ldt_sel_i,
   input wire logic ldt_ok_i,
   input wire logic [15:0] ss_sel_i,
   input wire logic [4:0] ss_type_i,
   input wire logic [1:0] ss_dpl_i,
   input wire logic [15:0] cs_sel_i,
   input wire logic [4:0] cs_type_i,
   input wire logic [1:0] cs_dpl_i,
   input wire logic [15:0] ds_sel_i,
   input wire logic [4:0] ds_type_i,
   input wire logic [1:0] ds_dpl_i,
   // Stack fetch on privilege change
   input wire logic stk_limit_fault_i,
   input wire logic stk_canon_fault_i,
   // Results
   output logic busy_o,
   output logic done_o,
   output logic fault_o,
   output logic [7:0] vector_o,
   output logic [15:0] err_code_o,
   output logic new_ctx_o,
   output logic [63:0] ret_ip_o,
   output logic commit_o,
   output logic seg_load_o
);
   import tsv_pkg::*;

   tsv_regs_t r_reg;
   tsv_regs_t r_next;

   // ==========================================================
   // Selector helpers
   function automatic logic sel_null(input logic [15:0] s);
      sel_null = (s[15:2] == 14'h0000);
   endfunction

   // Last byte of an 8-byte descriptor against the table limit
   function automatic logic over_lim(input logic [15:0] s, input logic [15:0] g,
                                     input logic [15:0] l);
      logic [15:0] lim;
      lim = s[2] ? l : g;
      over_lim = ({s[15:3], 3'h7} > lim);
   endfunction

   logic is_ts;
   logic tss_over;
   logic upper_over;
   logic tss_busy_t;
   logic tss_avail_t;
   logic link_busy_t;
   logic [4:0] pre_cause;
   logic [15:0] pre_sel;
   logic [4:0] post_cause;
   logic [15:0] post_sel;

   assign is_ts = (r_reg.op == TSV_OP_JMP) || (r_reg.op == TSV_OP_CALL)
                  || (r_reg.op == TSV_OP_EXC) || (r_reg.op == TSV_OP_INTERRUPT_RETURN_INSTRUCTION);
   assign tss_over = over_lim({tss_sel_i[15:3], 3'h0}, gdt_limit_i, gdt_limit_i);
   // Wide-mode descriptor spans 16 bytes; 17-bit sum avoids wrap
   assign upper_over = ({1'b0, tss_sel_i[15:3], 3'h0} + 17'h0000F) > {1'b0, gdt_limit_i};
   assign tss_busy_t = (tss_type_i == `TSV_T_BUSY16) || (tss_type_i == `TSV_T_BUSY32);
   assign tss_avail_t = (tss_type_i == `TSV_T_AVAIL16) || (tss_type_i == `TSV_T_AVAIL32);
   assign link_busy_t = (link_type_i == `TSV_T_BUSY16) || (link_type_i == `TSV_T_BUSY32);

   // ==========================================================
   // Checks before commit, first failure in fixed order wins
   always_comb begin
      pre_cause = 5'h00;
      pre_sel = tss_sel_i;
      if (r_reg.op == TSV_OP_LTR) begin
         if (sel_null(tss_sel_i) || tss_sel_i[2] || tss_over) begin
            pre_cause = 5'd15;
         end else if (r_reg.mode64 && upper_over) begin
            pre_cause = 5'd15;
         end else if (!tss_avail_t) begin
            pre_cause = 5'd15;
         end else if (r_reg.mode64 && ((tss_type_i == `TSV_T_AVAIL16)
                      || (tss_upper_type_i != `TSV_T_UPPER) || !tss_base_canon_i)) begin
            pre_cause = 5'd16;
         end
      end else if (r_reg.op == TSV_OP_PRIV) begin
         if (stk_limit_fault_i || (r_reg.mode64 && stk_canon_fault_i)) begin
            pre_cause = 5'd17;
         end
      end else if (tss_limit_i < (tss_is32_i ? `TSV_MIN_LIMIT_32 : `TSV_MIN_LIMIT_16)) begin
         pre_cause = 5'd1;
      end else if ((r_reg.op == TSV_OP_INTERRUPT_RETURN_INSTRUCTION) && (tss_sel_i[2] || tss_over || !tss_busy_t)) begin
         pre_cause = 5'd2;
      end else if ((r_reg.op == TSV_OP_INTERRUPT_RETURN_INSTRUCTION)
                   && (link_fetch_fault_i || sel_null(link_sel_i) || !link_busy_t)) begin
         pre_cause = 5'd3;
      end else if (tss_over || !new_writable_i) begin
         pre_cause = 5'd4;
      end else if (old_save_fault_i || (!old_writable_i
                   && ((r_reg.op == TSV_OP_JMP) || (r_reg.op == TSV_OP_INTERRUPT_RETURN_INSTRUCTION)))) begin
         pre_cause = 5'd5;
      end else if (((r_reg.op == TSV_OP_CALL) || (r_reg.op == TSV_OP_EXC))
                   && link_write_fault_i) begin
         pre_cause = 5'd6;
      end else if ((r_reg.op != TSV_OP_INTERRUPT_RETURN_INSTRUCTION)
                   && (sel_null(tss_sel_i) || tss_sel_i[2] || !tss_avail_t)) begin
         pre_cause = 5'd7;
      end
   end

   // ==========================================================
   // Checks after commit on the loaded selectors
   always_comb begin
      post_cause = 5'h00;
      post_sel = 16'h0000;
      if (!ldt_ok_i) begin
         post_cause = 5'd8;
         post_sel = ldt_sel_i;
      end else if (over_lim(ss_sel_i, gdt_limit_i, ldt_limit_i) || sel_null(ss_sel_i)
                   || !ss_type_i[4] || ss_type_i[3] || !ss_type_i[1]) begin
         post_cause = 5'd9;
         post_sel = ss_sel_i;
      end else if ((ss_dpl_i != cpl_i) || (ss_sel_i[1:0] != cpl_i)) begin
         post_cause = 5'd10;
         post_sel = ss_sel_i;
      end else if (over_lim(cs_sel_i, gdt_limit_i, ldt_limit_i) || sel_null(cs_sel_i)
                   || !cs_type_i[4] || !cs_type_i[3]) begin
         post_cause = 5'd11;
         post_sel = cs_sel_i;
      end else if (cs_type_i[2] ? (cs_dpl_i > cpl_i) : (cs_dpl_i != cpl_i)) begin
         post_cause = 5'd12;
         post_sel = cs_sel_i;
      end else if (!sel_null(ds_sel_i)) begin
         // A null data selector is legal and is not checked
         if (over_lim(ds_sel_i, gdt_limit_i, ldt_limit_i) || !ds_type_i[4]
             || (ds_type_i[3] && !ds_type_i[1])) begin
            post_cause = 5'd13;
            post_sel = ds_sel_i;
         end else if (ds_type_i[3] && !ds_type_i[2]
                      && ((ds_sel_i[1:0] > ds_dpl_i) || (cpl_i > ds_dpl_i))) begin
            post_cause = 5'd14;
            post_sel = ds_sel_i;
         end
      end
   end

   // ==========================================================
   // Sequencer and register file, one next-state image
   always_comb begin
      r_next = r_reg;
      r_next.fault = 1'b0;
      r_next.done = 1'b0;
      r_next.commit = 1'b0;
      r_next.seg_load = 1'b0;
      r_next.wb_ack = 1'b0;
      case (r_reg.st)
         TSV_ST_IDLE: begin
            if (start_i) begin
               r_next.op = op_i;
               r_next.busy = 1'b1;
               r_next.st = TSV_ST_PRE;
            end
         end
         TSV_ST_PRE: begin
            if (pre_cause != 5'h00) begin
               r_next.fault = 1'b1;
               r_next.new_ctx = 1'b0;
               r_next.cause = pre_cause;
               r_next.err = {pre_sel[15:2], 1'b0, ext_i};
               r_next.ret_ip = insn_ip_i;
               r_next.done = 1'b1;
               r_next.busy = 1'b0;
               r_next.st = TSV_ST_IDLE;
            end else if (is_ts) begin
               // Task register and back-link now hold the new task
               r_next.commit = 1'b1;
               r_next.st = TSV_ST_POST;
            end else begin
               r_next.done = 1'b1;
               r_next.busy = 1'b0;
               r_next.st = TSV_ST_IDLE;
            end
         end
         TSV_ST_POST: begin
            // All segment registers load even when a check fails
            r_next.seg_load = 1'b1;
            if (post_cause != 5'h00) begin
               r_next.fault = 1'b1;
               r_next.new_ctx = 1'b1;
               r_next.cause = post_cause;
               r_next.err = {post_sel[15:2], 1'b0, ext_i};
               r_next.ret_ip = new_ip_i;
            end
            r_next.done = 1'b1;
            r_next.busy = 1'b0;
            r_next.st = TSV_ST_IDLE;
         end
         default: begin
            r_next.st = TSV_ST_IDLE;
            r_next.busy = 1'b0;
         end
      endcase
      // Software view: answer one cycle after the request is taken
      if (wb_cyc_i && wb_stb_i && !r_reg.wb_ack) begin
         r_next.wb_ack = 1'b1;
         r_next.wb_dat = 32'h0000_0000;
         if (!wb_we_i) begin
            case (wb_adr_i)
               `TSV_OFS_CTRL: r_next.wb_dat[`TSV_CTRL_MODE64_BIT] = r_reg.mode64;
               `TSV_OFS_STATUS: begin
                  r_next.wb_dat[`TSV_STAT_CAUSE_LSB +: 5] = r_reg.last_cause;
                  r_next.wb_dat[`TSV_STAT_NEWCTX_BIT] = r_reg.last_ctx;
                  r_next.wb_dat[`TSV_STAT_VALID_BIT] = r_reg.stat_valid;
               end
               `TSV_OFS_ERRCODE: r_next.wb_dat[15:0] = r_reg.last_err;
               `TSV_OFS_COUNT: r_next.wb_dat[15:0] = r_reg.fault_cnt;
               default: r_next.wb_dat = 32'h0000_0000;
            endcase
         end
      end
      // Write lands at the edge where the master sees ack
      // Clear of valid loses to a fault in the same cycle
      if (wb_cyc_i && wb_stb_i && wb_we_i && r_reg.wb_ack) begin
         if ((wb_adr_i == `TSV_OFS_CTRL) && wb_sel_i[0]) begin
            r_next.mode64 = wb_dat_i[`TSV_CTRL_MODE64_BIT];
         end
         if ((wb_adr_i == `TSV_OFS_STATUS) && wb_sel_i[1]
             && wb_dat_i[`TSV_STAT_VALID_BIT]) begin
            r_next.stat_valid = 1'b0;
         end
      end
      if (r_next.fault) begin
         r_next.stat_valid = 1'b1;
         r_next.last_cause = r_next.cause;
         r_next.last_ctx = r_next.new_ctx;
         r_next.last_err = r_next.err;
         r_next.fault_cnt = r_reg.fault_cnt + 16'h0001;
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         r_reg <= '0;
         r_reg.st <= TSV_ST_IDLE;
         r_reg.mode64 <= `TSV_CTRL_RST;
         r_reg.fault_cnt <= `TSV_COUNT_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // Outputs straight from flops, except the constant vector_o
   assign busy_o = r_reg.busy;
   assign done_o = r_reg.done;
   assign fault_o = r_reg.fault;
   assign vector_o = `TSV_VECTOR;
   assign err_code_o = r_reg.err;
   assign new_ctx_o = r_reg.new_ctx;
   assign ret_ip_o = r_reg.ret_ip;
   assign commit_o = r_reg.commit;
   assign seg_load_o = r_reg.seg_load;
   assign wb_dat_o = r_reg.wb_dat;
   assign wb_ack_o = r_reg.wb_ack;

   // ==========================================================
   // Checks on the sequencer
   a_limit_fault: assert property (@(posedge clk_i) disable iff (rst_i)
      (r_reg.st == TSV_ST_PRE && is_ts && !tss_is32_i && tss_limit_i < 32'h2C)
      |=> fault_o && r_reg.cause == 5'd1)
      else $error("short task-state limit not faulted");
   a_ctx_before: assert property (@(posedge clk_i) disable iff (rst_i)
      (fault_o && !$past(commit_o)) |-> !new_ctx_o && ret_ip_o == $past(insn_ip_i))
      else $error("early fault not in old context");
   a_ctx_after: assert property (@(posedge clk_i) disable iff (rst_i)
      (fault_o && $past(commit_o)) |-> new_ctx_o && ret_ip_o == $past(new_ip_i))
      else $error("late fault not in new context");
   a_commit_post: assert property (@(posedge clk_i) disable iff (rst_i)
      commit_o |=> done_o && seg_load_o)
      else $error("commit not followed by segment load");
   a_seq_len: assert property (@(posedge clk_i) disable iff (rst_i)
      (start_i && !busy_o) |=> busy_o ##1 (done_o || commit_o))
      else $error("check sequence length wrong");
   a_ext_bit: assert property (@(posedge clk_i) disable iff (rst_i)
      fault_o |-> err_code_o[0] == $past(ext_i) && err_code_o[1] == 1'b0)
      else $error("error code flag bits wrong");
   a_ss_rpl: assert property (@(posedge clk_i) disable iff (rst_i)
      (r_reg.st == TSV_ST_POST && post_cause == 5'd10)
      |=> fault_o && err_code_o[15:2] == $past(ss_sel_i[15:2]))
      else $error("stack privilege fault wrong");
   a_ltr_null: assert property (@(posedge clk_i) disable iff (rst_i)
      (r_reg.st == TSV_ST_PRE && r_reg.op == TSV_OP_LTR && tss_sel_i[15:2] == 14'h0)
      |=> fault_o && !commit_o)
      else $error("null selector load not faulted");
   a_cnt_step: assert property (@(posedge clk_i) disable iff (rst_i)
      fault_o |-> r_reg.fault_cnt == $past(r_reg.fault_cnt) + 16'h0001)
      else $error("fault count not stepped");

   // ==========================================================
   // Checks on the bus and the result outputs
   a_ack_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
      wb_ack_o |=> !wb_ack_o)
      else $error("bus ack held too long");
   a_late_seg: assert property (@(posedge clk_i) disable iff (rst_i)
      (fault_o && new_ctx_o) |-> seg_load_o && done_o)
      else $error("late fault without segment load");
   a_no_commit: assert property (@(posedge clk_i) disable iff (rst_i)
      (r_reg.st == TSV_ST_PRE && !is_ts) |=> !commit_o)
      else $error("commit outside a task switch");
   a_done_idle: assert property (@(posedge clk_i) disable iff (rst_i)
      done_o |-> !busy_o)
      else $error("busy still high at done");
   a_err_hold: assert property (@(posedge clk_i) disable iff (rst_i)
      !fault_o |-> $stable(err_code_o))
      else $error("error code changed without fault");
endmodule

//--- tsv_fault_unit_tb_top.sv
`timescale 1ns/10ps
`include "tsv_consts.svh"
module tsv_fault_unit_tb_top;
   import tsv_pkg::*;
   // ==========================================================
   // Harness
   logic clk_i = 1'b0, rst_i = 1'b1, start_i = 1'b0, ext_i;
   logic wb_we_i = 1'b0, wb_stb_i = 1'b0, wb_cyc_i = 1'b0;
   logic [7:0] wb_adr_i = 8'h00, vector_o;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, tss_limit_i;
   logic [3:0] wb_sel_i = 4'h0;
   tsv_op_t op_i;
   logic [1:0] cpl_i, ss_dpl_i, cs_dpl_i, ds_dpl_i;
   logic [15:0] gdt_limit_i, ldt_limit_i, tss_sel_i, link_sel_i, ldt_sel_i, err_code_o;
   logic [15:0] ss_sel_i, cs_sel_i, ds_sel_i;
   logic [63:0] insn_ip_i, new_ip_i, ret_ip_o;
   logic [4:0] tss_type_i, tss_upper_type_i, link_type_i, ss_type_i, cs_type_i, ds_type_i;
   logic tss_is32_i, tss_base_canon_i, new_writable_i, old_save_fault_i, old_writable_i;
   logic link_write_fault_i, link_fetch_fault_i, ldt_ok_i, stk_limit_fault_i, stk_canon_fault_i;
   logic wb_ack_o, busy_o, done_o, fault_o, new_ctx_o, commit_o, seg_load_o;
   int error_cnt = 0, n_checks = 0, n_faults = 0;

   tsv_fault_unit tsv_fault_unit_i (.clk_i, .rst_i, .wb_adr_i, .wb_dat_i, .wb_dat_o, .wb_we_i,
      .wb_sel_i, .wb_stb_i, .wb_cyc_i, .wb_ack_o, .start_i, .op_i, .ext_i, .cpl_i, .gdt_limit_i,
      .ldt_limit_i, .insn_ip_i, .new_ip_i, .tss_sel_i, .tss_limit_i, .tss_is32_i, .tss_type_i,
      .tss_upper_type_i, .tss_base_canon_i, .new_writable_i, .old_save_fault_i, .old_writable_i,
      .link_write_fault_i, .link_fetch_fault_i, .link_sel_i, .link_type_i, .ldt_sel_i, .ldt_ok_i,
      .ss_sel_i, .ss_type_i, .ss_dpl_i, .cs_sel_i, .cs_type_i, .cs_dpl_i, .ds_sel_i, .ds_type_i,
      .ds_dpl_i, .stk_limit_fault_i, .stk_canon_fault_i, .busy_o, .done_o, .fault_o, .vector_o,
      .err_code_o, .new_ctx_o, .ret_ip_o, .commit_o, .seg_load_o);

   // 50 ns period
   initial begin
      forever #25 clk_i = ~clk_i;
   end

   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      begin
         n_checks++;
         if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
         end
      end
   endtask

   // A task state that passes every check except the busy type a return switch needs; cases disturb one field
   task automatic base();
      begin
         {cpl_i, gdt_limit_i, ldt_limit_i} <= {2'h0, 16'hFFFF, 16'hFFFF};
         {insn_ip_i, new_ip_i} <= {64'h0000_0000_0000_1000, 64'h0000_0000_0000_2000};
         {tss_sel_i, tss_limit_i, tss_is32_i} <= {16'h0028, 32'h0000_0067, 1'b1};
         {tss_type_i, tss_upper_type_i} <= {`TSV_T_AVAIL32, `TSV_T_UPPER};
         {ext_i, tss_base_canon_i, new_writable_i, old_writable_i} <= 4'h7;
         {old_save_fault_i, link_write_fault_i, link_fetch_fault_i} <= 3'h0;
         {stk_limit_fault_i, stk_canon_fault_i} <= 2'h0;
         {link_sel_i, link_type_i, ldt_sel_i, ldt_ok_i} <= {16'h0030, `TSV_T_BUSY32, 16'h0040, 1'b1};
         {ss_sel_i, ss_type_i, ss_dpl_i} <= {16'h0010, 5'h12, 2'h0};
         {cs_sel_i, cs_type_i, cs_dpl_i} <= {16'h0008, 5'h1A, 2'h0};
         {ds_sel_i, ds_type_i, ds_dpl_i} <= {16'h0018, 5'h12, 2'h0};
      end
   endtask

   // One request; dn is the cycle of done, 3 only for committed switches
   task automatic run(input tsv_op_t op, input logic ef, input int dn, input logic [15:0] ee);
      int n;
      logic late;
      begin
         late = (dn == 3);
         op_i <= op;
         start_i <= 1'b1;
         @(posedge clk_i);
         start_i <= 1'b0;
         n = 0;
         while (done_o !== 1'b1 && n < 6) begin
            @(posedge clk_i);
            n++;
            if (n == 1) chk("busy", busy_o, 1'b1);
            if (n == 2) chk("commit", commit_o, late);
         end
         chk("done cycle", n, dn);
         chk("fault", fault_o, ef);
         chk("seg load", seg_load_o, late);
         chk("vector", vector_o, 8'h0A);
         if (ef) begin
            n_faults++;
            chk("context", new_ctx_o, late);
            chk("err code", err_code_o, ee);
            chk("ret ip", ret_ip_o, late ? new_ip_i : insn_ip_i);
         end
         base();
         @(posedge clk_i);
      end
   endtask

   // Classic cycle: hold until ack is sampled, then one idle cycle
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q);
      begin
         {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'h3, we, a, d, s};
         do begin
            @(posedge clk_i);
         end while (wb_ack_o !== 1'b1);
         q = wb_dat_o;
         {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'h0;
         @(posedge clk_i);
      end
   endtask

   task automatic wrap_up();
      begin
         $display("checks %0d mismatches %0d", n_checks, error_cnt);
         if (error_cnt == 0 && n_checks > 0) begin
            $display("Finished cleanly");
         end else begin
            $display("Finished with errors");
         end
         $finish;
      end
   endtask

   // ==========================================================
   // Scenarios
   task automatic t_sel();
      begin
         tss_limit_i <= 32'h0000_0066;
         run(TSV_OP_JMP, 1'b1, 2, 16'h0028);
         {tss_is32_i, tss_type_i, tss_limit_i} <= {1'b0, `TSV_T_AVAIL16, 32'h0000_002B};
         run(TSV_OP_JMP, 1'b1, 2, 16'h0028);
         {tss_is32_i, tss_type_i, tss_limit_i} <= {1'b0, `TSV_T_AVAIL16, 32'h0000_002C};
         run(TSV_OP_JMP, 1'b0, 3, 16'h0000);
         gdt_limit_i <= 16'h002E;
         run(TSV_OP_JMP, 1'b1, 2, 16'h0028);
         new_writable_i <= 1'b0;
         run(TSV_OP_CALL, 1'b1, 2, 16'h0028);
         old_save_fault_i <= 1'b1;
         run(TSV_OP_JMP, 1'b1, 2, 16'h0028);
         old_writable_i <= 1'b0;
         run(TSV_OP_CALL, 1'b0, 3, 16'h0000);
         old_writable_i <= 1'b0;
         run(TSV_OP_JMP, 1'b1, 2, 16'h0028);
         link_write_fault_i <= 1'b1;
         run(TSV_OP_EXC, 1'b1, 2, 16'h0028);
         tss_sel_i <= 16'h0000;
         run(TSV_OP_JMP, 1'b1, 2, 16'h0000);
         tss_sel_i <= 16'h002C;
         run(TSV_OP_JMP, 1'b1, 2, 16'h002C);
         tss_type_i <= `TSV_T_BUSY32;
         run(TSV_OP_JMP, 1'b1, 2, 16'h0028);
         {ext_i, tss_limit_i} <= {1'b1, 32'h0000_0066};
         run(TSV_OP_CALL, 1'b1, 2, 16'h0029);
      end
   endtask

   task automatic t_interrupt_return_instruction();
      begin
         tss_type_i <= `TSV_T_BUSY32;
         run(TSV_OP_INTERRUPT_RETURN_INSTRUCTION, 1'b0, 3, 16'h0000);
         {tss_type_i, tss_sel_i} <= {`TSV_T_BUSY32, 16'h002C};
         run(TSV_OP_INTERRUPT_RETURN_INSTRUCTION, 1'b1, 2, 16'h002C);
         run(TSV_OP_INTERRUPT_RETURN_INSTRUCTION, 1'b1, 2, 16'h0028);
         {tss_type_i, link_fetch_fault_i} <= {`TSV_T_BUSY32, 1'b1};
         run(TSV_OP_INTERRUPT_RETURN_INSTRUCTION, 1'b1, 2, 16'h0028);
         {tss_type_i, link_sel_i} <= {`TSV_T_BUSY32, 16'h0003};
         run(TSV_OP_INTERRUPT_RETURN_INSTRUCTION, 1'b1, 2, 16'h0028);
         {tss_type_i, link_type_i} <= {`TSV_T_BUSY32, `TSV_T_AVAIL32};
         run(TSV_OP_INTERRUPT_RETURN_INSTRUCTION, 1'b1, 2, 16'h0028);
      end
   endtask

   // Faults found after commit, in the new task
   task automatic t_late();
      begin
         ldt_ok_i <= 1'b0;
         run(TSV_OP_JMP, 1'b1, 3, 16'h0040);
         ss_type_i <= 5'h1A;
         run(TSV_OP_JMP, 1'b1, 3, 16'h0010);
         ss_type_i <= 5'h10;
         run(TSV_OP_CALL, 1'b1, 3, 16'h0010);
         ss_sel_i <= 16'h0011;
         run(TSV_OP_JMP, 1'b1, 3, 16'h0010);
         cpl_i <= 2'h1;
         run(TSV_OP_JMP, 1'b1, 3, 16'h0010);
         cs_type_i <= 5'h12;
         run(TSV_OP_JMP, 1'b1, 3, 16'h0008);
         {cs_type_i, cs_dpl_i} <= {5'h1E, 2'h1};
         run(TSV_OP_JMP, 1'b1, 3, 16'h0008);
         ds_type_i <= 5'h18;
         run(TSV_OP_JMP, 1'b1, 3, 16'h0018);
         {ds_sel_i, ldt_limit_i} <= {16'h001C, 16'h0017};
         run(TSV_OP_JMP, 1'b1, 3, 16'h001C);
         {ds_type_i, ds_sel_i} <= {5'h1A, 16'h0019};
         run(TSV_OP_JMP, 1'b1, 3, 16'h0018);
         {cpl_i, ss_sel_i, ss_dpl_i} <= {2'h1, 16'h0011, 2'h1};
         {cs_type_i, ds_type_i} <= {5'h1E, 5'h1A};
         run(TSV_OP_JMP, 1'b1, 3, 16'h0018);
         {ext_i, ss_dpl_i, cs_type_i} <= {1'b1, 2'h1, 5'h12};
         run(TSV_OP_EXC, 1'b1, 3, 16'h0011);
      end
   endtask

   task automatic t_ltr();
      logic [31:0] q;
      begin
         wb(1'b0, 8'h00, 32'h0000_0000, 4'hF, q);
         chk("ctrl reset", q, 32'h0000_0000);
         run(TSV_OP_LTR, 1'b0, 2, 16'h0000);
         tss_sel_i <= 16'h0000;
         run(TSV_OP_LTR, 1'b1, 2, 16'h0000);
         tss_sel_i <= 16'h0004;
         run(TSV_OP_LTR, 1'b1, 2, 16'h0004);
         tss_type_i <= `TSV_T_BUSY32;
         run(TSV_OP_LTR, 1'b1, 2, 16'h0028);
         {tss_type_i, tss_is32_i} <= {`TSV_T_AVAIL16, 1'b0};
         run(TSV_OP_LTR, 1'b0, 2, 16'h0000);
         wb(1'b1, 8'h00, 32'h0000_0001, 4'h1, q);
         {tss_type_i, tss_is32_i} <= {`TSV_T_AVAIL16, 1'b0};
         run(TSV_OP_LTR, 1'b1, 2, 16'h0028);
         tss_upper_type_i <= `TSV_T_AVAIL32;
         run(TSV_OP_LTR, 1'b1, 2, 16'h0028);
         tss_base_canon_i <= 1'b0;
         run(TSV_OP_LTR, 1'b1, 2, 16'h0028);
         stk_canon_fault_i <= 1'b1;
         run(TSV_OP_PRIV, 1'b1, 2, 16'h0028);
         wb(1'b1, 8'h00, 32'h0000_0000, 4'h1, q);
         stk_canon_fault_i <= 1'b1;
         run(TSV_OP_PRIV, 1'b0, 2, 16'h0000);
         stk_limit_fault_i <= 1'b1;
         run(TSV_OP_PRIV, 1'b1, 2, 16'h0028);
      end
   endtask

   // Last fault was the stack fetch limit, old context
   task automatic t_regs();
      logic [31:0] q;
      begin
         wb(1'b0, 8'h04, 32'h0000_0000, 4'hF, q);
         chk("status", q, 32'h0000_0211);
         wb(1'b0, 8'h08, 32'h0000_0000, 4'hF, q);
         chk("err reg", q, 32'h0000_0028);
         wb(1'b0, 8'h0C, 32'h0000_0000, 4'hF, q);
         chk("count", q, n_faults);
         wb(1'b1, 8'h04, 32'h0000_0200, 4'h2, q);
         wb(1'b0, 8'h04, 32'h0000_0000, 4'hF, q);
         chk("valid", q[9], 1'b0);
         wb(1'b0, 8'h10, 32'h0000_0000, 4'hF, q);
         chk("unmapped", q, 32'h0000_0000);
      end
   endtask

   initial begin
      base();
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      chk("vector", vector_o, 8'h0A);
      t_sel();
      t_interrupt_return_instruction();
      t_late();
      t_ltr();
      t_regs();
      wrap_up();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk_i);
      error_cnt++;
      wrap_up();
   end
endmodule
